// >>> hdl/lcdsr_map.svh
`ifndef LCDSR_MAP_SVH
`define LCDSR_MAP_SVH

// reference clock and reset-busy time
`define LCDSR_CLK_PERIOD_NS 40
`define LCDSR_RST_BUSY_NS 200
`define LCDSR_RST_BUSY_CYC ((`LCDSR_RST_BUSY_NS + `LCDSR_CLK_PERIOD_NS - 1) / `LCDSR_CLK_PERIOD_NS)

// display memory geometry
`define LCDSR_COLS 132
`define LCDSR_MAIN_PAGES 8
`define LCDSR_MAIN_BYTES (`LCDSR_COLS * `LCDSR_MAIN_PAGES)
`define LCDSR_COL_STOP 8'h84
`define LCDSR_ICON_PAGE 4'h8

// reset values
`define LCDSR_RATIO_RST 3'h4
`define LCDSR_VOL_RST 6'h20

// status byte bit positions
`define LCDSR_STAT_BUSY_BIT 7
`define LCDSR_STAT_ADC_BIT 6
`define LCDSR_STAT_OFF_BIT 5
`define LCDSR_STAT_RESET_BIT 4

// command byte patterns
`define LCDSR_CMD_DISP_ONOFF 7'h57
`define LCDSR_CMD_ADC 7'h50
`define LCDSR_CMD_BIAS 7'h51
`define LCDSR_CMD_ALL_POINTS 7'h52
`define LCDSR_CMD_REVERSE 7'h53
`define LCDSR_CMD_INDICATOR 7'h56
`define LCDSR_CMD_START_LINE 2'h1
`define LCDSR_CMD_PAGE 4'hB
`define LCDSR_CMD_COL_HI 4'h1
`define LCDSR_CMD_COL_LO 4'h0
`define LCDSR_CMD_COM_DIR 4'hC
`define LCDSR_CMD_POWER 5'h05
`define LCDSR_CMD_RATIO 5'h04
`define LCDSR_CMD_RMW 8'hE0
`define LCDSR_CMD_RMW_END 8'hEE
`define LCDSR_CMD_RESET 8'hE2
`define LCDSR_CMD_VOLUME 8'h81
`define LCDSR_CMD_BOOST 8'hF8

`endif

// >>> hdl/lcdsr_pkg.sv
`default_nettype none
package lcdsr_pkg;

    typedef struct packed {
        logic display_on;
        logic all_points;
        logic reverse;
        logic adc_rev;
        logic com_rev;
        logic bias;
        logic osc_on;
        logic power_save;
        logic rmw;
        logic ind_on;
        logic [1:0] indicator_mode_bits;
        logic [2:0] power_ctl;
        logic [2:0] regulator_ratio_bits;
        logic [5:0] volume_level_bits;
    } lcdsr_cfg_type;

    typedef struct packed {
        logic dc;
        logic [7:0] data;
    } lcdsr_byte_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_VOLUME,
        ST_INDIC,
        ST_BOOST,
        ST_RESET
    } lcdsr_state_type;

endpackage
`default_nettype wire

// >>> hdl/lcdsr_top.sv
`include "lcdsr_map.svh"
`default_nettype none
module lcdsr_top
    import lcdsr_pkg::*;
#(
    parameter int P_RST_BUSY_CYC = `LCDSR_RST_BUSY_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_serial_clock_line,
    input wire logic i_serial_data_or_busy_bit,
    input wire logic i_chip_select_n,
    input wire logic i_data_command_select_pin,
    input wire logic i_frame_start,
    input wire logic i_line_clock,
    output var lcdsr_cfg_type o_cfg,
    output logic [7:0] o_status,
    output logic o_busy,
    output logic [3:0] o_page,
    output logic [7:0] o_column,
    output logic [5:0] o_start_line,
    output logic [5:0] o_line_addr,
    output logic [131:0] o_row_data,
    output logic [131:0] o_icon_data
);

    if (P_RST_BUSY_CYC < 1 || P_RST_BUSY_CYC > 256) begin : g_chk
        $error("P_RST_BUSY_CYC must be 1 to 256");
    end

    localparam logic [7:0] RST_CNT_INIT = 8'(P_RST_BUSY_CYC - 1);
    localparam lcdsr_cfg_type CFG_RST = '{
        regulator_ratio_bits: `LCDSR_RATIO_RST,
        volume_level_bits: `LCDSR_VOL_RST,
        default: '0
    };

    // link domain: runs only while the host clocks a byte
    logic lk_rst_n;
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic lk_last;
    lcdsr_byte_type lk_byte;
    lcdsr_byte_type hold0_q;
    lcdsr_byte_type hold1_q;
    logic tog_q;

    assign lk_rst_n = i_resetn & ~i_chip_select_n;
    assign lk_last = (cnt_q == 3'h7);
    assign lk_byte = '{
        dc: i_data_command_select_pin,
        data: {shift_q[6:0], i_serial_data_or_busy_bit}
    };

    always_ff @(posedge i_serial_clock_line or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
            shift_q <= 8'h00;
            cnt_q <= 3'h0;
        end else begin
            shift_q <= {shift_q[6:0], i_serial_data_or_busy_bit};
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // two slots so a byte stays stable for a full byte time after the toggle
    always_ff @(posedge i_serial_clock_line or negedge i_resetn) begin
        if (!i_resetn) begin
            hold0_q <= '0;
            hold1_q <= '0;
            tog_q <= 1'b0;
        end else if (lk_last) begin
            if (tog_q) begin
                hold0_q <= lk_byte;
            end else begin
                hold1_q <= lk_byte;
            end
            tog_q <= ~tog_q;
        end
    end

    // reference domain
    logic [2:0] tog_sync_q;
    logic ev;
    lcdsr_byte_type rx;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tog_sync_q <= 3'h0;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], tog_q};
        end
    end

    assign ev = tog_sync_q[2] ^ tog_sync_q[1];
    assign rx = tog_sync_q[1] ? hold1_q : hold0_q;

    lcdsr_state_type state_q;
    lcdsr_state_type state_d;
    lcdsr_cfg_type cfg_q;
    lcdsr_cfg_type cfg_d;
    logic [3:0] page_q;
    logic [3:0] page_d;
    logic [7:0] col_q;
    logic [7:0] col_d;
    logic [5:0] start_q;
    logic [5:0] start_d;
    logic [7:0] rst_cnt_q;
    logic [7:0] rst_cnt_d;

    logic busy, cmd_ev, data_ev, col_run;
    assign busy = (state_q == ST_RESET);
    assign cmd_ev = ev & ~rx.dc & ~busy;
    assign data_ev = ev & rx.dc & ~busy;
    assign col_run = (col_q < `LCDSR_COL_STOP);

    logic dec_disp, dec_start, dec_page, dec_col_hi, dec_col_lo;
    logic dec_adc, dec_bias, dec_all, dec_rev, dec_ind;
    logic dec_com, dec_pwr, dec_ratio;
    assign dec_disp = (rx.data[7:1] == `LCDSR_CMD_DISP_ONOFF);
    assign dec_start = (rx.data[7:6] == `LCDSR_CMD_START_LINE);
    assign dec_page = (rx.data[7:4] == `LCDSR_CMD_PAGE);
    assign dec_col_hi = (rx.data[7:4] == `LCDSR_CMD_COL_HI);
    assign dec_col_lo = (rx.data[7:4] == `LCDSR_CMD_COL_LO);
    assign dec_adc = (rx.data[7:1] == `LCDSR_CMD_ADC);
    assign dec_bias = (rx.data[7:1] == `LCDSR_CMD_BIAS);
    assign dec_all = (rx.data[7:1] == `LCDSR_CMD_ALL_POINTS);
    assign dec_rev = (rx.data[7:1] == `LCDSR_CMD_REVERSE);
    assign dec_ind = (rx.data[7:1] == `LCDSR_CMD_INDICATOR);
    assign dec_com = (rx.data[7:4] == `LCDSR_CMD_COM_DIR);
    assign dec_pwr = (rx.data[7:3] == `LCDSR_CMD_POWER);
    assign dec_ratio = (rx.data[7:3] == `LCDSR_CMD_RATIO);

    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        page_d = page_q;
        col_d = col_q;
        start_d = start_q;
        rst_cnt_d = rst_cnt_q;
        unique case (state_q)
            ST_RESET: begin
                cfg_d = CFG_RST;
                page_d = 4'h0;
                col_d = 8'h00;
                start_d = 6'h00;
                if (rst_cnt_q == 8'h00) begin
                    state_d = ST_IDLE;
                end else begin
                    rst_cnt_d = rst_cnt_q - 8'h01;
                end
            end
            ST_VOLUME: begin
                if (cmd_ev) begin
                    cfg_d.volume_level_bits = rx.data[5:0];
                    state_d = ST_IDLE;
                end
            end
            ST_INDIC: begin
                if (cmd_ev) begin
                    cfg_d.indicator_mode_bits = rx.data[1:0];
                    state_d = ST_IDLE;
                end
            end
            ST_BOOST: begin
                // booster is fixed on this module; value byte only consumed
                if (cmd_ev) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (cmd_ev) begin
                    if (dec_disp) begin
                        cfg_d.display_on = rx.data[0];
                        cfg_d.osc_on = cfg_q.osc_on | rx.data[0];
                    end else if (dec_start) begin
                        start_d = rx.data[5:0];
                    end else if (dec_page) begin
                        page_d = rx.data[3:0];
                    end else if (dec_col_hi) begin
                        col_d = {rx.data[3:0], col_q[3:0]};
                    end else if (dec_col_lo) begin
                        col_d = {col_q[7:4], rx.data[3:0]};
                    end else if (dec_adc) begin
                        cfg_d.adc_rev = rx.data[0];
                    end else if (dec_bias) begin
                        cfg_d.bias = rx.data[0];
                    end else if (dec_all) begin
                        cfg_d.all_points = rx.data[0];
                    end else if (dec_rev) begin
                        cfg_d.reverse = rx.data[0];
                    end else if (dec_ind) begin
                        cfg_d.ind_on = rx.data[0];
                        state_d = ST_INDIC;
                    end else if (dec_com) begin
                        cfg_d.com_rev = rx.data[3];
                    end else if (dec_pwr) begin
                        cfg_d.power_ctl = rx.data[2:0];
                    end else if (dec_ratio) begin
                        cfg_d.regulator_ratio_bits = rx.data[2:0];
                    end else if (rx.data == `LCDSR_CMD_RMW) begin
                        cfg_d.rmw = 1'b1;
                    end else if (rx.data == `LCDSR_CMD_RMW_END) begin
                        cfg_d.rmw = 1'b0;
                    end else if (rx.data == `LCDSR_CMD_RESET) begin
                        state_d = ST_RESET;
                        rst_cnt_d = RST_CNT_INIT;
                    end else if (rx.data == `LCDSR_CMD_VOLUME) begin
                        state_d = ST_VOLUME;
                    end else if (rx.data == `LCDSR_CMD_BOOST) begin
                        state_d = ST_BOOST;
                    end
                end
            end
        endcase
        // writes only exist on this link, so rmw mode still advances here
        if (data_ev && col_run) begin
            col_d = col_q + 8'h01;
        end
        cfg_d.power_save = ~cfg_d.display_on & cfg_d.all_points;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_RESET;
            rst_cnt_q <= RST_CNT_INIT;
            cfg_q <= CFG_RST;
            page_q <= 4'h0;
            col_q <= 8'h00;
            start_q <= 6'h00;
        end else begin
            state_q <= state_d;
            rst_cnt_q <= rst_cnt_d;
            cfg_q <= cfg_d;
            page_q <= page_d;
            col_q <= col_d;
            start_q <= start_d;
        end
    end

    // display memory: eight byte pages plus one icon row
    logic [7:0] ram_q [0:`LCDSR_MAIN_BYTES-1];
    logic [131:0] icon_q;
    logic [10:0] wr_idx;
    logic wr_main;
    logic wr_icon;
    logic col_ok;
    assign col_ok = (col_q < 8'(`LCDSR_COLS));
    assign wr_idx = 11'(11'(page_q[2:0]) * 11'(`LCDSR_COLS) + 11'(col_q));
    assign wr_main = data_ev & col_ok & (page_q < `LCDSR_ICON_PAGE);
    assign wr_icon = data_ev & col_ok & (page_q == `LCDSR_ICON_PAGE);

    // no reset on the array: contents are undefined until written
    always_ff @(posedge i_ref_clk) begin
        if (wr_main) begin
            ram_q[wr_idx] <= rx.data;
        end
        if (wr_icon) begin
            icon_q[col_q] <= rx.data[0];
        end
    end

    // scan side: reads in parallel with host writes
    logic [5:0] line_q;
    logic [131:0] row_d;
    logic [131:0] icon_d;
    logic [131:0] row_q;
    logic [131:0] icon_row_q;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            line_q <= 6'h00;
        end else if (i_frame_start) begin
            line_q <= start_q;
        end else if (i_line_clock) begin
            line_q <= line_q + 6'h01;
        end
    end

    for (genvar s = 0; s < `LCDSR_COLS; s++) begin : g_seg
        logic [7:0] c;
        logic [10:0] idx;
        logic raw;
        assign c = cfg_q.adc_rev ? 8'(`LCDSR_COLS - 1 - s) : 8'(s);
        assign idx = 11'(11'(line_q[5:3]) * 11'(`LCDSR_COLS) + 11'(c));
        assign raw = ram_q[idx][line_q[2:0]];
        assign row_d[s] = cfg_q.display_on & (cfg_q.all_points | (raw ^ cfg_q.reverse));
        // icon row ignores the start line
        assign icon_d[s] = cfg_q.display_on &
            (cfg_q.all_points | (icon_q[c] ^ cfg_q.reverse));
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            row_q <= '0;
            icon_row_q <= '0;
        end else begin
            row_q <= row_d;
            icon_row_q <= icon_d;
        end
    end

    always_comb begin
        o_status = 8'h00;
        o_status[`LCDSR_STAT_BUSY_BIT] = busy;
        o_status[`LCDSR_STAT_ADC_BIT] = cfg_q.adc_rev;
        o_status[`LCDSR_STAT_OFF_BIT] = ~cfg_q.display_on;
        o_status[`LCDSR_STAT_RESET_BIT] = busy;
    end

    assign o_busy = busy;
    assign o_cfg = cfg_q;
    assign o_page = page_q;
    assign o_column = col_q;
    assign o_start_line = start_q;
    assign o_line_addr = line_q;
    assign o_row_data = row_q;
    assign o_icon_data = icon_row_q;

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    AST_DESELECT_CLEAR: assert property (
        i_chip_select_n && $past(i_chip_select_n) |-> (cnt_q == 3'h0) && (shift_q == 8'h00)
    ) else $error("serial state not cleared while deselected");
    AST_PAGE_ONLY_CMD: assert property (
        $changed(page_q) |-> $past(cmd_ev && dec_page && state_q == ST_IDLE) || $past(busy)
    ) else $error("page changed without page command");
    AST_COL_INC: assert property (
        data_ev && col_run |=> col_q == $past(col_q) + 8'h01
    ) else $error("column did not advance by one");
    AST_COL_LOCK: assert property (
        data_ev && !col_run |=> $stable(col_q)
    ) else $error("locked column moved");
    AST_PAGE_INDEP: assert property (
        data_ev |=> $stable(page_q)
    ) else $error("data write changed page");
    AST_LINE_LOAD: assert property (
        i_frame_start |=> line_q == $past(start_q)
    ) else $error("line counter not loaded at frame start");
    AST_SOFT_RESET: assert property (
        cmd_ev && state_q == ST_IDLE && rx.data == `LCDSR_CMD_RESET
        |=> busy ##1 (col_q == 8'h00) && (page_q == 4'h0) && (start_q == 6'h00)
    ) else $error("reset command did not clear addresses");
    AST_RESET_VALUES: assert property (
        busy ##1 busy |-> cfg_q.volume_level_bits == `LCDSR_VOL_RST &&
            cfg_q.regulator_ratio_bits == `LCDSR_RATIO_RST && cfg_q.power_ctl == 3'h0
    ) else $error("reset values wrong");
    // a byte slipping through while busy would bump the column or move the page
    AST_BUSY_IGNORE: assert property (
        busy && ev |=> (col_q == 8'h00) && (page_q == 4'h0)
    ) else $error("write accepted while busy");
    AST_ICON_BIT: assert property (
        wr_icon |=> icon_q[$past(col_q)] == $past(rx.data[0])
    ) else $error("icon bit not stored");
    AST_BUSY_STATUS: assert property (
        o_status[`LCDSR_STAT_BUSY_BIT] == busy && o_status[`LCDSR_STAT_RESET_BIT] == busy
    ) else $error("status bits disagree with busy");
    AST_BUSY_SOURCE: assert property (
        $rose(busy) |-> $past(cmd_ev && rx.data == `LCDSR_CMD_RESET)
    ) else $error("busy rose without reset command");

    COV_SOFT_RESET: cover property (cmd_ev && rx.data == `LCDSR_CMD_RESET);
    COV_ICON_WRITE: cover property (wr_icon);
    COV_COL_LOCK: cover property (data_ev && !col_run);
    COV_FRAME: cover property (i_frame_start ##[1:20] i_line_clock);

endmodule
`default_nettype wire

// >>> test/lcdsr_host.sv
`default_nettype none
module lcdsr_host (
    output logic o_serial_clock_line,
    output logic o_serial_data_or_busy_bit,
    output logic o_chip_select_n,
    output logic o_data_command_select_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_serial_clock_line = 1'b0;
        o_serial_data_or_busy_bit = 1'b1;
        o_chip_select_n = 1'b1;
        o_data_command_select_pin = 1'b0;
    end

    // top n bits of b, msb first; n below 8 aborts the byte
    task automatic send_bits(input logic dc, input logic [7:0] b, input int n);
        #3.7;
        o_data_command_select_pin = dc;
        o_chip_select_n = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            o_serial_data_or_busy_bit = b[i];
            #6 o_serial_clock_line = 1'b1;
            #6 o_serial_clock_line = 1'b0;
        end
        o_chip_select_n = 1'b1;
        // released lines flip so a stale level is never mistaken for data
        o_serial_data_or_busy_bit = ~o_serial_data_or_busy_bit;
        o_data_command_select_pin = ~dc;
        #6;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_lcd_serial_ram_addressing.sv
`include "lcdsr_map.svh"
`default_nettype none
module tb_lcd_serial_ram_addressing
    import lcdsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_frame_start = 1'b0;
    logic i_line_clock = 1'b0;
    logic sclk;
    logic sdata;
    logic cs_n;
    logic dc;
    lcdsr_cfg_type o_cfg;
    logic [7:0] o_status;
    logic o_busy;
    logic [3:0] o_page;
    logic [7:0] o_column;
    logic [5:0] o_start_line;
    logic [5:0] o_line_addr;
    logic [131:0] o_row_data;
    logic [131:0] o_icon_data;
    int n_errors = 0;
    int checks = 0;
    logic rst_seen;
    lcdsr_cfg_type exp_cfg;

    always #20 i_ref_clk = ~i_ref_clk;

    lcdsr_host host_u (
        .o_serial_clock_line(sclk),
        .o_serial_data_or_busy_bit(sdata),
        .o_chip_select_n(cs_n),
        .o_data_command_select_pin(dc)
    );

    lcdsr_top dut_u (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_serial_clock_line(sclk),
        .i_serial_data_or_busy_bit(sdata),
        .i_chip_select_n(cs_n),
        .i_data_command_select_pin(dc),
        .i_frame_start(i_frame_start),
        .i_line_clock(i_line_clock),
        .o_cfg(o_cfg),
        .o_status(o_status),
        .o_busy(o_busy),
        .o_page(o_page),
        .o_column(o_column),
        .o_start_line(o_start_line),
        .o_line_addr(o_line_addr),
        .o_row_data(o_row_data),
        .o_icon_data(o_icon_data)
    );

    task automatic check(input logic [131:0] seen, input logic [131:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    // decode lands 2-3 ref edges after the last bit, outputs one later
    task automatic wr(input logic d, input logic [7:0] b);
        host_u.send_bits(d, b, 8);
        settle(6);
    endtask

    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask

    task automatic wait_ready();
        for (int k = 0; k < 50 && o_busy !== 1'b0; k++) @(posedge i_ref_clk);
        check(o_busy, 1'b0);
        if (o_busy !== 1'b0) tally_and_finish();
    endtask

    task automatic check_defaults();
        exp_cfg = '0;
        exp_cfg.regulator_ratio_bits = `LCDSR_RATIO_RST;
        exp_cfg.volume_level_bits = `LCDSR_VOL_RST;
        check(o_cfg, exp_cfg);
        check({o_page, o_column, o_start_line}, 18'h0);
    endtask

    task automatic do_reset(input int n);
        @(posedge i_ref_clk) i_resetn <= 1'b0;
        settle(n);
        check(o_status, 8'hB0);
        check(o_busy, 1'b1);
        check_defaults();
        @(posedge i_ref_clk) i_resetn <= 1'b1;
        wait_ready();
        check(o_status, 8'h20);
    endtask

    task automatic pulse(input logic f);
        @(posedge i_ref_clk);
        i_frame_start <= f;
        i_line_clock <= ~f;
        @(posedge i_ref_clk);
        i_frame_start <= 1'b0;
        i_line_clock <= 1'b0;
        settle(3);
    endtask

    initial begin
        do_reset(20);
        end_test("reset");

        wr(0, 8'hB3);
        check(o_page, 4'h3);
        wr(0, 8'h18);
        wr(0, 8'h03);
        check(o_column, 8'h83);
        wr(1, 8'hAA);
        check(o_column, `LCDSR_COL_STOP);
        wr(1, 8'h55);
        check(o_column, `LCDSR_COL_STOP);
        check(o_page, 4'h3);
        wr(0, 8'h02);
        wr(0, 8'h10);
        check(o_column, 8'h02);
        wr(1, 8'h00);
        check(o_column, 8'h03);
        end_test("column");

        // aborted byte must leave no bits behind
        host_u.send_bits(0, 8'hB0, 3);
        settle(2);
        wr(0, 8'hB5);
        check(o_page, 4'h5);
        end_test("link");

        wr(0, 8'hB0);
        wr(0, 8'h10);
        wr(0, 8'h00);
        wr(0, 8'hAF);
        check(o_status, 8'h00);
        wr(1, 8'h01);
        wr(1, 8'h02);
        wr(0, 8'h40);
        pulse(1);
        check(o_line_addr, 6'h00);
        check(o_row_data[1:0], 2'b01);
        pulse(0);
        check(o_line_addr, 6'h01);
        check(o_row_data[1:0], 2'b10);
        wr(0, 8'hA1);
        check(o_status, 8'h40);
        wr(0, 8'h10);
        wr(0, 8'h00);
        wr(1, 8'h01);
        wr(1, 8'h02);
        check(o_row_data[131:130], 2'b01);
        wr(0, 8'hA0);
        end_test("ram");

        wr(0, 8'hB8);
        wr(0, 8'h10);
        wr(0, 8'h05);
        wr(1, 8'h01);
        wr(1, 8'hFE);
        wr(1, 8'h00);
        wr(0, 8'hB9);
        wr(0, 8'h06);
        wr(1, 8'hFF);
        check(o_page, 4'h9);
        check(o_icon_data[7:5], 3'b001);
        wr(0, 8'h4A);
        check(o_start_line, 6'h0A);
        pulse(1);
        check(o_line_addr, 6'h0A);
        check(o_icon_data[7:5], 3'b001);
        wr(0, 8'h7F);
        pulse(1);
        pulse(0);
        check(o_line_addr, 6'h00);
        end_test("icon");

        wr(0, 8'h81);
        wr(0, 8'h3F);
        check(o_cfg.volume_level_bits, 6'h3F);
        wr(0, 8'h23);
        wr(0, 8'h2F);
        wr(0, 8'hAD);
        wr(0, 8'h02);
        check({o_cfg.regulator_ratio_bits, o_cfg.power_ctl}, 6'h1F);
        check({o_cfg.ind_on, o_cfg.indicator_mode_bits}, 3'h6);
        wr(0, 8'hC8);
        wr(0, 8'hA3);
        wr(0, 8'hA7);
        wr(0, 8'hE0);
        check({o_cfg.com_rev, o_cfg.bias, o_cfg.reverse, o_cfg.rmw}, 4'hF);
        wr(0, 8'h10);
        wr(0, 8'h02);
        wr(0, 8'hF8);
        wr(0, 8'h01);
        check(o_column, 8'h02);
        wr(0, 8'hA5);
        check(o_row_data, {132{1'b1}});
        wr(0, 8'hAE);
        check({o_cfg.display_on, o_cfg.power_save}, 2'b01);
        check(o_row_data, 132'h0);
        wr(0, 8'hEE);
        check(o_cfg.rmw, 1'b0);
        end_test("modes");
        rst_seen = 1'b0;
        fork
            begin
                host_u.send_bits(0, 8'hE2, 8);
                host_u.send_bits(0, 8'hB7, 8);
            end
            for (int k = 0; k < 30; k++) begin
                @(posedge i_ref_clk);
                if (o_status[`LCDSR_STAT_RESET_BIT] === 1'b1) rst_seen = 1'b1;
            end
        join
        check(rst_seen, 1'b1);
        wait_ready();
        check_defaults();
        end_test("soft reset");

        wr(0, 8'hB4);
        wr(0, 8'h81);
        wr(0, 8'h01);
        do_reset(2);
        end_test("hard reset");
        tally_and_finish();
    end
endmodule
`default_nettype wire
